/* File: include/cal_ctrl_consts.vh */
// Constants of the converter core calibration controller.
`ifndef CAL_CTRL_CONSTS_VH
`define CAL_CTRL_CONSTS_VH
// Register indices; byte address is four times the index.
`define CAL_IDX_CTRL 8'h00
`define CAL_IDX_STATUS 8'h01
`define CAL_IDX_TRIM_BASE 8'h40
`define CAL_IDX_SRC_DLY 8'h9A
`define CAL_IDX_SEL_DLY 8'h9B
`define CAL_IDX_TRIM_MASK 8'hF0
// Control register fields.
`define CAL_CTRL_SOFT_BIT 0
`define CAL_CTRL_SRC_BIT 1
`define CAL_CTRL_BG_BIT 2
`define CAL_CTRL_VAR_LSB 4
`define CAL_CTRL_VAR_MSB 5
// Status register fields.
`define CAL_STAT_DONE_BIT 0
`define CAL_STAT_BUSY_BIT 1
`define CAL_STAT_BG_BIT 2
`define CAL_STAT_CORE_LSB 4
`define CAL_STAT_CORE_MSB 6
`define CAL_STAT_ROUTE_LSB 8
`define CAL_STAT_ROUTE_MSB 19
// Channel variants.
`define CAL_VAR_QUAD 2'h0
`define CAL_VAR_DUAL 2'h1
`define CAL_VAR_SINGLE 2'h2
// Reset values.
`define CAL_RST_CTRL 8'h00
`define CAL_RST_SRC_DLY 8'h00
`define CAL_RST_SEL_DLY 8'h00
// Core numbers and default routing, input 0 in the low three bits.
`define CAL_NUM_CORES 6
`define CAL_LAST_CORE 3'h5
`define CAL_SPARE_A 3'h2
`define CAL_SPARE_B 3'h3
`define CAL_ROUTE_DEFAULT 12'hB08
`define CAL_MIDCODE 12'h000
// Trim store: 6 offset, 6 gain, 4 termination words.
`define CAL_TRIM_WORDS 16
`define CAL_TRIM_LAST 5'h0F
// Timing: one core pass lasts 10 us at 100 MHz.
`define CAL_PASS_TIME_NS 10000
`define CAL_CLK_PERIOD_NS 10
`define CAL_PASS_CYCLES (`CAL_PASS_TIME_NS / `CAL_CLK_PERIOD_NS)
`endif

/* File: rtl/adc_core_calibration_ctrl.v */
// Calibration sequencer for six converter cores with an AHB-Lite register slave.
//
// The AHB-Lite register port was decided locally.
`timescale 1ns/100ps
`include "cal_ctrl_consts.vh"

// Notes on behaviour
// - Foreground pass takes all cores offline and forces mid-code output.
// - Background pass keeps converting; a calibrated core stands in for the offline one.
// - Six cores numbered zero to five, two of them spares.
// - Foreground routing: cores 0, 1, 4, 5 feed inputs one to four.
// - Quad: spare 2 rotates with cores 0 and 1, spare 3 with 4 and 5.
// - Dual: spare 2 shared between cores 0 and 1.
// - Single: spare 2 is the only alternate for core 0.
// - Calibrated core samples the internal reference, not the inputs.
// - One foreground pass runs automatically after every power-up.
// - Foreground starts from pin or software trigger, chosen by source select.
// - Only one core is calibrated at any moment.
// - Calibrated core replaces the next active core, repeating while enabled.
// - Trims load factory values at power-up and stay readable and writable.
module adc_core_calibration_ctrl #(
  parameter PASS_CYCLES = `CAL_PASS_CYCLES
) (
  // Clock and reset.
  input wire clk_i,
  input wire reset_n_i,
  // AHB-Lite slave.
  input wire hsel_i,
  input wire [31:0] haddr_i,
  input wire [1:0] htrans_i,
  input wire hwrite_i,
  input wire [2:0] hsize_i,
  input wire [31:0] hwdata_i,
  input wire hready_i,
  output reg hreadyout_o,
  output reg hresp_o,
  output reg [31:0] hrdata_o,
  // Trigger pin.
  input wire external_trigger_pin_i,
  // Factory trim source.
  output reg [3:0] factory_addr_o,
  input wire [7:0] factory_data_i,
  // Core control.
  output reg [5:0] core_offline_o,
  output reg [5:0] core_calibrating_o,
  output reg [5:0] core_ref_select_o,
  output reg force_midcode_o,
  output reg [11:0] sample_data_o,
  output reg [11:0] input_route_o,
  output reg [7:0] core_source_delay_o,
  output reg [7:0] output_select_delay_o,
  output reg cal_done_o
);
  localparam ST_LOAD = 5'b00001;
  localparam ST_IDLE = 5'b00010;
  localparam ST_FG = 5'b00100;
  localparam ST_BG = 5'b01000;
  localparam ST_SWAP = 5'b10000;

  // -----------------------------------------------------------------
  // Helper functions
  // -----------------------------------------------------------------
  function [5:0] onehot;
    input [2:0] core;
    begin
      onehot = 6'h01 << core;
    end
  endfunction

  // Cores that feed inputs in use for the given variant.
  function [5:0] active_cores;
    input [11:0] route;
    input [1:0] variant;
    begin
      active_cores = onehot(route[2:0]);
      if (variant != `CAL_VAR_SINGLE) begin
        active_cores = active_cores | onehot(route[5:3]);
      end
      if (variant == `CAL_VAR_QUAD) begin
        active_cores = active_cores | onehot(route[8:6]) | onehot(route[11:9]);
      end
    end
  endfunction

  // -----------------------------------------------------------------
  // Declarations
  // -----------------------------------------------------------------
  reg trig_meta;
  reg trig_sync;
  reg trig_prev;
  reg [7:0] ctrl;
  reg [4:0] state;
  reg [4:0] load_idx;
  reg [2:0] cal_core;
  reg [2:0] spare0;
  reg [2:0] spare1;
  reg group;
  reg turn0;
  reg turn1;
  reg fg_req;
  reg timer_start;
  reg [15:0] timer_count;
  reg dp_valid;
  reg dp_write;
  reg dp_wait;
  reg [7:0] dp_idx;
  reg [1:0] victim;
  reg [2:0] victim_core;
  wire timer_done;
  wire [7:0] trim_rdata;
  wire trig_level;
  wire trig_edge;
  wire bg_go;
  wire [1:0] variant;
  wire addr_phase;
  wire trim_hit;
  wire trim_wr;
  wire mem_we;
  wire [3:0] mem_waddr;
  wire [7:0] mem_wdata;
  wire [7:0] idx_in;
  wire [31:0] status_word;

  assign variant = ctrl[`CAL_CTRL_VAR_MSB:`CAL_CTRL_VAR_LSB];
  assign trig_level = ctrl[`CAL_CTRL_SRC_BIT] ? trig_sync : ctrl[`CAL_CTRL_SOFT_BIT];
  assign trig_edge = trig_level & ~trig_prev;
  assign bg_go = ctrl[`CAL_CTRL_BG_BIT] & ~ctrl[`CAL_CTRL_SRC_BIT] & ctrl[`CAL_CTRL_SOFT_BIT];

  // -----------------------------------------------------------------
  // Trigger pin synchroniser
  // -----------------------------------------------------------------
  always @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      trig_meta <= 1'b0;
      trig_sync <= 1'b0;
      trig_prev <= 1'b0;
    end else begin
      trig_meta <= external_trigger_pin_i;
      trig_sync <= trig_meta;
      trig_prev <= trig_level;
    end
  end

  // -----------------------------------------------------------------
  // Trim store and pass timer
  // -----------------------------------------------------------------
  // The loader owns the write port until factory values are in place.
  assign mem_we = (state == ST_LOAD) | trim_wr;
  assign mem_waddr = (state == ST_LOAD) ? load_idx[3:0] : dp_idx[3:0];
  assign mem_wdata = (state == ST_LOAD) ? factory_data_i : hwdata_i[7:0];

  cal_trim_store u_trim (
    .clk_i(clk_i),
    .wr_en_i(mem_we),
    .wr_addr_i(mem_waddr),
    .wr_data_i(mem_wdata),
    // The data phase uses its own index, as the bus may already show the next address.
    .rd_addr_i(addr_phase ? idx_in[3:0] : dp_idx[3:0]),
    .rd_data_o(trim_rdata)
  );

  cal_pass_timer u_timer (
    .clk_i(clk_i),
    .reset_n_i(reset_n_i),
    .start_i(timer_start),
    .count_i(timer_count),
    .done_o(timer_done)
  );

  // -----------------------------------------------------------------
  // Sequencer
  // -----------------------------------------------------------------
  // Pick the input whose core is swapped out next in the current group.
  always @* begin
    if (group) begin
      victim = turn1 ? 2'h3 : 2'h2;
    end else if (variant == `CAL_VAR_SINGLE) begin
      victim = 2'h0;
    end else begin
      victim = turn0 ? 2'h1 : 2'h0;
    end
    victim_core = input_route_o[3 * victim +: 3];
  end

  always @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state <= ST_LOAD;
      load_idx <= 5'h00;
      factory_addr_o <= 4'h0;
      cal_core <= 3'h0;
      spare0 <= `CAL_SPARE_A;
      spare1 <= `CAL_SPARE_B;
      group <= 1'b0;
      turn0 <= 1'b0;
      turn1 <= 1'b0;
      fg_req <= 1'b0;
      timer_start <= 1'b0;
      timer_count <= 16'h0000;
      input_route_o <= `CAL_ROUTE_DEFAULT;
      cal_done_o <= 1'b0;
    end else begin
      timer_start <= 1'b0;
      if (trig_edge & ~ctrl[`CAL_CTRL_BG_BIT]) begin
        fg_req <= 1'b1;
      end
      case (state)
        ST_LOAD: begin
          // Factory values are copied before the power-up pass starts.
          load_idx <= load_idx + 5'h01;
          factory_addr_o <= load_idx[3:0] + 4'h1;
          if (load_idx == `CAL_TRIM_LAST) begin
            state <= ST_FG;
            cal_core <= 3'h0;
            timer_start <= 1'b1;
            timer_count <= PASS_CYCLES[15:0];
          end
        end
        ST_IDLE: begin
          if (fg_req) begin
            if (!(trig_edge & ~ctrl[`CAL_CTRL_BG_BIT])) begin
              fg_req <= 1'b0;
            end
            state <= ST_FG;
            cal_done_o <= 1'b0;
            cal_core <= 3'h0;
            timer_start <= 1'b1;
            timer_count <= PASS_CYCLES[15:0];
          end else if (bg_go) begin
            state <= ST_BG;
            cal_core <= group ? spare1 : spare0;
            timer_start <= 1'b1;
            timer_count <= PASS_CYCLES[15:0];
          end
        end
        ST_FG: begin
          // Cores are calibrated one after another, all held offline.
          if (timer_done) begin
            if (cal_core == `CAL_LAST_CORE) begin
              state <= ST_IDLE;
              cal_done_o <= 1'b1;
              input_route_o <= `CAL_ROUTE_DEFAULT;
              spare0 <= `CAL_SPARE_A;
              spare1 <= `CAL_SPARE_B;
              group <= 1'b0;
              turn0 <= 1'b0;
              turn1 <= 1'b0;
            end else begin
              cal_core <= cal_core + 3'h1;
              timer_start <= 1'b1;
            end
          end
        end
        ST_BG: begin
          // Output select settles before the route changes over.
          if (timer_done) begin
            state <= ST_SWAP;
            timer_start <= 1'b1;
            timer_count <= {8'h00, output_select_delay_o};
          end
        end
        ST_SWAP: begin
          if (timer_done) begin
            input_route_o[3 * victim +: 3] <= cal_core;
            if (group) begin
              spare1 <= victim_core;
              turn1 <= ~turn1;
            end else begin
              spare0 <= victim_core;
              turn0 <= ~turn0;
            end
            // Quad alternates groups; other variants use group zero only.
            group <= (variant == `CAL_VAR_QUAD) ? ~group : 1'b0;
            if (bg_go & ~fg_req) begin
              state <= ST_BG;
              cal_core <= victim_core;
              if (variant == `CAL_VAR_QUAD) begin
                cal_core <= group ? spare0 : spare1;
              end
              timer_start <= 1'b1;
              timer_count <= PASS_CYCLES[15:0];
            end else begin
              state <= ST_IDLE;
            end
          end
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  // -----------------------------------------------------------------
  // Core control outputs
  // -----------------------------------------------------------------
  always @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      core_offline_o <= 6'h3F;
      core_calibrating_o <= 6'h00;
      core_ref_select_o <= 6'h00;
      force_midcode_o <= 1'b1;
      sample_data_o <= `CAL_MIDCODE;
    end else begin
      if (state == ST_FG || state == ST_LOAD) begin
        core_offline_o <= 6'h3F;
        force_midcode_o <= 1'b1;
        sample_data_o <= `CAL_MIDCODE;
      end else begin
        core_offline_o <= ~active_cores(input_route_o, variant);
        force_midcode_o <= 1'b0;
        sample_data_o <= `CAL_MIDCODE;
      end
      // A single pass covers one core, so at most one bit is set.
      if (state == ST_FG || state == ST_BG) begin
        core_calibrating_o <= onehot(cal_core);
        core_ref_select_o <= onehot(cal_core);
      end else begin
        core_calibrating_o <= 6'h00;
        core_ref_select_o <= 6'h00;
      end
    end
  end

  // -----------------------------------------------------------------
  // AHB-Lite slave
  // -----------------------------------------------------------------
  assign addr_phase = hsel_i & htrans_i[1] & hready_i;
  assign idx_in = haddr_i[9:2];
  assign trim_hit = ((dp_idx & `CAL_IDX_TRIM_MASK) == `CAL_IDX_TRIM_BASE);
  assign trim_wr = dp_valid & dp_write & trim_hit & (state != ST_LOAD);
  assign status_word = {12'h000, input_route_o, 1'b0, cal_core, 1'b0,
                        (state == ST_BG || state == ST_SWAP), (state == ST_FG), cal_done_o};

  always @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      dp_valid <= 1'b0;
      dp_write <= 1'b0;
      dp_wait <= 1'b0;
      dp_idx <= 8'h00;
      hreadyout_o <= 1'b1;
      hresp_o <= 1'b0;
      hrdata_o <= 32'h00000000;
      ctrl <= `CAL_RST_CTRL;
      core_source_delay_o <= `CAL_RST_SRC_DLY;
      output_select_delay_o <= `CAL_RST_SEL_DLY;
    end else begin
      if (addr_phase) begin
        dp_valid <= 1'b1;
        dp_write <= hwrite_i;
        dp_idx <= idx_in;
        // Reads take one wait state so the data leave a flip-flop.
        dp_wait <= ~hwrite_i;
        hreadyout_o <= hwrite_i;
      end else if (dp_wait) begin
        dp_wait <= 1'b0;
        hreadyout_o <= 1'b1;
        if (trim_hit) begin
          hrdata_o <= {24'h000000, trim_rdata};
        end else begin
          case (dp_idx)
            `CAL_IDX_CTRL: hrdata_o <= {24'h000000, ctrl};
            `CAL_IDX_STATUS: hrdata_o <= status_word;
            `CAL_IDX_SRC_DLY: hrdata_o <= {24'h000000, core_source_delay_o};
            `CAL_IDX_SEL_DLY: hrdata_o <= {24'h000000, output_select_delay_o};
            default: hrdata_o <= 32'h00000000;
          endcase
        end
      end else if (hready_i) begin
        dp_valid <= 1'b0;
      end
      if (dp_valid & dp_write & ~dp_wait) begin
        case (dp_idx)
          `CAL_IDX_CTRL: ctrl <= {2'b00, hwdata_i[5:4], 1'b0, hwdata_i[2:0]};
          `CAL_IDX_SRC_DLY: core_source_delay_o <= hwdata_i[7:0];
          `CAL_IDX_SEL_DLY: output_select_delay_o <= hwdata_i[7:0];
          default: ctrl <= ctrl;
        endcase
      end
      hresp_o <= 1'b0;
    end
  end
endmodule // adc_core_calibration_ctrl

/* File: rtl/cal_pass_timer.v */
// Down counter that pulses done a programmed number of cycles after start.
`timescale 1ns/100ps
module cal_pass_timer (
  // Clock and reset.
  input wire clk_i,
  input wire reset_n_i,
  // Control.
  input wire start_i,
  input wire [15:0] count_i,
  // Result.
  output reg done_o
);
  reg [15:0] remain;
  reg running;

  // Done comes count_i plus one cycles after start.
  always @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      remain <= 16'h0000;
      running <= 1'b0;
      done_o <= 1'b0;
    end else begin
      done_o <= 1'b0;
      if (start_i) begin
        remain <= count_i;
        running <= 1'b1;
      end else if (running) begin
        if (remain == 16'h0000) begin
          running <= 1'b0;
          done_o <= 1'b1;
        end else begin
          remain <= remain - 16'h0001;
        end
      end
    end
  end
endmodule // cal_pass_timer

/* File: rtl/cal_trim_store.v */
// Trim value store with one write port and a registered read port.
`timescale 1ns/100ps
module cal_trim_store (
  // Clock.
  input wire clk_i,
  // Write port.
  input wire wr_en_i,
  input wire [3:0] wr_addr_i,
  input wire [7:0] wr_data_i,
  // Read port.
  input wire [3:0] rd_addr_i,
  output reg [7:0] rd_data_o
);
  reg [7:0] mem [0:15];

  always @(posedge clk_i) begin
    if (wr_en_i) begin
      mem[wr_addr_i] <= wr_data_i;
    end
    rd_data_o <= mem[rd_addr_i];
  end
endmodule // cal_trim_store

/* File: testbench/adc_core_calibration_ctrl_test.sv */
// Self-checking bench for the calibration sequencer.
`timescale 1ns/100ps
`include "cal_ctrl_consts.vh"
module adc_core_calibration_ctrl_test;
  logic clk_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic hsel_i = 1'b0;
  logic [31:0] haddr_i = 32'h0;
  logic [1:0] htrans_i = 2'h0;
  logic hwrite_i = 1'b0;
  logic [31:0] hwdata_i = 32'h0;
  wire hready_i;
  wire hreadyout_o, hresp_o, cal_done_o, force_midcode_o, trig;
  wire [31:0] hrdata_o;
  wire [3:0] faddr;
  wire [7:0] fdata, src_dly, sel_dly;
  wire [5:0] offl, calib, refs;
  wire [11:0] sdata, route;
  int failures = 0;
  int cmp_count = 0;
  int cycles = 0;
  logic [31:0] rd;
  logic [5:0] seen, first;
  logic mid;
  logic [7:0] row_idx [6] = '{`CAL_IDX_SRC_DLY, `CAL_IDX_SEL_DLY, `CAL_IDX_TRIM_BASE, `CAL_IDX_STATUS, 8'hFF,
    `CAL_IDX_CTRL};
  logic [31:0] row_wr [6] = '{32'hFFFFFF1F, 32'h1E, 32'hA5, 32'h0, 32'hFFFFFFFF, 32'hC8};
  // Status after a pass still names core 5, the last one calibrated.
  logic [31:0] row_rd [6] = '{32'h1F, 32'h1E, 32'hA5, 32'h000B0851, 32'h0, 32'h0};
  logic [5:0] bg_seen [3] = '{6'h3F, 6'h07, 6'h05};
  assign hready_i = hreadyout_o;
  adc_core_calibration_ctrl #(.PASS_CYCLES(4)) u_dut (.clk_i(clk_i), .reset_n_i(reset_n_i), .hsel_i(hsel_i),
    .haddr_i(haddr_i), .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hsize_i(3'h2), .hwdata_i(hwdata_i),
    .hready_i(hready_i), .hreadyout_o(hreadyout_o), .hresp_o(hresp_o), .hrdata_o(hrdata_o),
    .external_trigger_pin_i(trig), .factory_addr_o(faddr), .factory_data_i(fdata), .core_offline_o(offl),
    .core_calibrating_o(calib), .core_ref_select_o(refs), .force_midcode_o(force_midcode_o),
    .sample_data_o(sdata), .input_route_o(route), .core_source_delay_o(src_dly),
    .output_select_delay_o(sel_dly), .cal_done_o(cal_done_o));
  cal_host_model u_host (.clk_i(clk_i), .factory_addr_i(faddr), .factory_data_o(fdata), .trigger_pin_o(trig));
  initial begin
    forever #5 clk_i = ~clk_i;
  end
  // ----------------------------------------
  // Bus and checking tasks
  // ----------------------------------------
  task automatic stop_test();
    $display("comparisons %0d failures %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      failures++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic bus(input logic wr, input logic [7:0] idx, input logic [31:0] d);
    @(posedge clk_i);
    hsel_i <= 1'b1;
    htrans_i <= 2'h2;
    haddr_i <= {22'h0, idx, 2'h0};
    hwrite_i <= wr;
    do @(posedge clk_i); while (hreadyout_o !== 1'b1);
    hsel_i <= 1'b0;
    htrans_i <= 2'h0;
    hwdata_i <= d;
    do @(posedge clk_i); while (hreadyout_o !== 1'b1);
    rd = hrdata_o;
  endtask
  task automatic rdc(input string n, input logic [7:0] idx, input logic [31:0] exp);
    bus(1'b0, idx, 32'h0);
    chk(n, exp, rd);
    chk("response", 32'h0, {31'h0, hresp_o});
  endtask
  task automatic wait_fg();
    int n = 0;
    while (force_midcode_o !== 1'b1 && n < 50) begin
      @(posedge clk_i);
      n++;
    end
    chk("pass started", 32'h1, {31'h0, force_midcode_o});
    n = 0;
    while (cal_done_o !== 1'b1 && n < 300) begin
      @(posedge clk_i);
      n++;
    end
    chk("pass done", 32'h1, {31'h0, cal_done_o});
  endtask
  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 10000) begin
      failures++;
      stop_test();
    end
  end
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    repeat (20) @(posedge clk_i);
    chk("reset route", 32'hB08, {20'h0, route});
    chk("reset offline", 32'h3F, {26'h0, offl});
    chk("reset done", 32'h0, {31'h0, cal_done_o});
    chk("reset delay", 32'h0, {24'h0, src_dly});
    reset_n_i <= 1'b1;
    // A write landing in the trim load window must be lost.
    bus(1'b1, `CAL_IDX_TRIM_BASE + 8'h0F, 32'h0);
    wait_fg();
    for (int i = 0; i < 16; i++) begin
      rdc("factory trim", `CAL_IDX_TRIM_BASE + i[7:0], {24'h0, 4'hC, i[3:0]});
    end
    for (int i = 0; i < 6; i++) begin
      bus(1'b1, row_idx[i], row_wr[i]);
      rdc("register row", row_idx[i], row_rd[i]);
    end
    chk("source delay port", 32'h1F, {24'h0, src_dly});
    chk("select delay port", 32'h1E, {24'h0, sel_dly});
    bus(1'b1, `CAL_IDX_CTRL, 32'h2);
    bus(1'b1, `CAL_IDX_CTRL, 32'h3);
    repeat (20) @(posedge clk_i);
    chk("soft ignored", 32'h1, {31'h0, cal_done_o});
    u_host.pulse();
    wait_fg();
    bus(1'b1, `CAL_IDX_CTRL, 32'h0);
    for (int v = 0; v < 3; v++) begin
      bus(1'b1, `CAL_IDX_CTRL, {26'h0, v[1:0], 4'h5});
      seen = 6'h00;
      mid = 1'b0;
      repeat (600) begin
        @(posedge clk_i);
        if (seen == 6'h00 && calib != 6'h00) first = calib;
        seen |= calib;
        mid |= force_midcode_o;
      end
      chk("first core", 32'h04, {26'h0, first});
      chk("cores cycled", {26'h0, bg_seen[v]}, {26'h0, seen});
      chk("bg output live", 32'h0, {31'h0, mid});
      bus(1'b1, `CAL_IDX_CTRL, {26'h0, v[1:0], 4'h0});
      repeat (100) @(posedge clk_i);
      chk("bg stopped", 32'h0, {26'h0, calib});
      bus(1'b1, `CAL_IDX_CTRL, {26'h0, v[1:0], 4'h1});
      wait_fg();
      chk("route restored", 32'hB08, {20'h0, route});
    end
    // Reset in the middle of a background pass restarts from factory state.
    bus(1'b1, `CAL_IDX_CTRL, 32'h5);
    repeat (50) @(posedge clk_i);
    reset_n_i <= 1'b0;
    @(posedge clk_i);
    chk("mid reset calibrating", 32'h0, {26'h0, calib});
    chk("mid reset route", 32'hB08, {20'h0, route});
    chk("mid reset done", 32'h0, {31'h0, cal_done_o});
    reset_n_i <= 1'b1;
    wait_fg();
    rdc("trim reloaded", `CAL_IDX_TRIM_BASE, 32'hC0);
    stop_test();
  end
endmodule // adc_core_calibration_ctrl_test
bind adc_core_calibration_ctrl cal_ctrl_chk u_chk (.clk_i(clk_i), .reset_n_i(reset_n_i), .hsel_i(hsel_i),
  .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hready_i(hready_i), .hreadyout_o(hreadyout_o),
  .core_offline_o(core_offline_o), .core_calibrating_o(core_calibrating_o), .core_ref_select_o(core_ref_select_o),
  .force_midcode_o(force_midcode_o), .sample_data_o(sample_data_o), .input_route_o(input_route_o),
  .cal_done_o(cal_done_o));

/* File: testbench/cal_ctrl_chk.sv */
// Concurrent property checker for the calibration sequencer ports.
`timescale 1ns/100ps
module cal_ctrl_chk (
  // Clock and reset.
  input wire clk_i,
  input wire reset_n_i,
  // Bus handshake.
  input wire hsel_i,
  input wire [1:0] htrans_i,
  input wire hwrite_i,
  input wire hready_i,
  input wire hreadyout_o,
  // Core control.
  input wire [5:0] core_offline_o,
  input wire [5:0] core_calibrating_o,
  input wire [5:0] core_ref_select_o,
  input wire force_midcode_o,
  input wire [11:0] sample_data_o,
  input wire [11:0] input_route_o,
  input wire cal_done_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);
  // Cores currently feeding an input; while output is not forced to mid-code, a core under calibration must not be one of them.
  wire [5:0] routed = (6'h01 << input_route_o[2:0]) | (6'h01 << input_route_o[5:3])
    | (6'h01 << input_route_o[8:6]) | (6'h01 << input_route_o[11:9]);
  wire groups_ok = input_route_o[2:0] < 3'h3 && input_route_o[5:3] < 3'h3
    && input_route_o[8:6] > 3'h2 && input_route_o[8:6] < 3'h6
    && input_route_o[11:9] > 3'h2 && input_route_o[11:9] < 3'h6;
  property p_midcode; force_midcode_o |-> sample_data_o == 12'h000; endproperty
  a_midcode: assert property (p_midcode) else $error("sample not mid-code while forced");
  property p_fg_offline; force_midcode_o && core_calibrating_o != 6'h00 |-> core_offline_o == 6'h3F; endproperty
  a_fg_offline: assert property (p_fg_offline) else $error("core online during foreground pass");
  property p_one_core; $onehot0(core_calibrating_o); endproperty
  a_one_core: assert property (p_one_core) else $error("several cores calibrating");
  property p_ref; core_ref_select_o == core_calibrating_o; endproperty
  a_ref: assert property (p_ref) else $error("reference select differs from calibrating core");
  property p_bg_live; !force_midcode_o |-> (core_calibrating_o & (routed | ~core_offline_o)) == 6'h00; endproperty
  a_bg_live: assert property (p_bg_live) else $error("calibrating core still in service");
  property p_groups; groups_ok; endproperty
  a_groups: assert property (p_groups) else $error("core routed outside its group");
  property p_done_route; $rose(cal_done_o) |-> ##[0:1] input_route_o == 12'hB08; endproperty
  a_done_route: assert property (p_done_route) else $error("routing not default after pass");
  property p_done_free; $rose(cal_done_o) |-> ##[0:1] !force_midcode_o; endproperty
  a_done_free: assert property (p_done_free) else $error("output still forced after done");
  property p_read; hsel_i && htrans_i[1] && hready_i && !hwrite_i |=> !hreadyout_o ##1 hreadyout_o; endproperty
  a_read: assert property (p_read) else $error("read wait state wrong");
  c_done: cover property ($rose(cal_done_o));
  c_bg: cover property (!force_midcode_o && core_calibrating_o != 6'h00);
  c_read: cover property (!hreadyout_o);
endmodule // cal_ctrl_chk

/* File: testbench/cal_host_model.sv */
// Host side model: factory trim source and calibration trigger pin.
`timescale 1ns/100ps
module cal_host_model (
  // Clock.
  input wire clk_i,
  // Factory trim source.
  input wire [3:0] factory_addr_i,
  output wire [7:0] factory_data_o,
  // Trigger pin.
  output logic trigger_pin_o
);
  // Each word differs so a load from the wrong address shows up.
  assign factory_data_o = {4'hC, factory_addr_i};
  initial trigger_pin_o = 1'b0;
  // Held several cycles so the two-stage synchroniser surely sees the edge.
  task automatic pulse();
    @(posedge clk_i);
    trigger_pin_o <= 1'b1;
    repeat (4) @(posedge clk_i);
    trigger_pin_o <= 1'b0;
  endtask
endmodule // cal_host_model
